// >>> bench/err_msg_partner.sv
`timescale 1ns/100ps
//==========================================================
// Link partner that sends received error messages
module err_msg_partner (
   input wire logic sys_clk, // Core clock
   input wire logic [2:0] send, // Fatal, non-fatal, correctable
   output logic msg_fatal_rx, // Fatal message strobe
   output logic msg_nonfatal_rx, // Non-fatal message strobe
   output logic msg_cor_rx // Correctable message strobe
);
   // One strobe per request, launched after the edge
   always_ff @(posedge sys_clk) begin
      {msg_fatal_rx, msg_nonfatal_rx, msg_cor_rx} <= send;
   end
endmodule

// >>> bench/test_pcie_port_error_first_next_log.sv
`timescale 1ns/100ps
//==========================================================
// Bench for the first/next error log
module test_pcie_port_error_first_next_log;
   import err_log_pkg::*;
   logic sys_clk = 1'b0; // Core clock
   logic nrst = 1'b0; // System reset
   logic por_n = 1'b0; // Power-on reset
   logic serr_en = 1'b1; // Message enable
   logic [8:0] ev = 9'h000; // Wanted events, log bit order
   logic [8:0] ev_d = 9'h000; // Aligned with partner delay
   logic [11:0] reg_addr = 12'h000; // Register address
   logic [31:0] reg_wdata = 32'h0; // Write data
   logic reg_wr = 1'b0; // Write strobe
   logic reg_rd = 1'b0; // Read strobe
   logic [31:0] reg_rdata; // Read data
   logic mf, mn, mc; // Message strobes
   int err_total = 0; // Mismatches
   int compares = 0; // Comparisons
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   // Delay local events so they meet the messages
   always_ff @(posedge sys_clk) ev_d <= ev;
   err_msg_partner err_msg_partner_inst (.sys_clk(sys_clk), .send(ev[2:0]),
      .msg_fatal_rx(mf), .msg_nonfatal_rx(mn), .msg_cor_rx(mc));
   pcie_port_error_first_next_log pcie_port_error_first_next_log_inst (.sys_clk(sys_clk),
      .nrst(nrst), .por_n(por_n), .dev_fatal_det(ev_d[8]), .dev_nonfatal_det(ev_d[7]),
      .dev_cor_det(ev_d[6]), .unit_fatal_det(ev_d[5]), .unit_nonfatal_det(ev_d[4]),
      .unit_cor_det(ev_d[3]), .msg_fatal_rx(mf), .msg_nonfatal_rx(mn), .msg_cor_rx(mc),
      .serr_en(serr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   //=======================================================
   // Shared tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(what, exp, reg_rdata);
   endtask
   task automatic fire(input logic [8:0] v);
      @(posedge sys_clk);
      ev <= v;
      @(posedge sys_clk);
      ev <= 9'h000;
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic rst_pulse(input logic por);
      @(posedge sys_clk);
      if (por) por_n <= 1'b0; else nrst <= 1'b0;
      @(posedge sys_clk);
      por_n <= 1'b1;
      nrst <= 1'b1;
   endtask
   //=======================================================
   // Scenarios
   task automatic t_bits;
      for (int k = 0; k < LOG_BITS; k++) begin
         fire(9'h001 << k);
         rd(FIRST_ERR_OFS, 32'h1 << k, "first");
         fire(9'h001 << k);
         rd(NEXT_ERR_OFS, 32'h1 << k, "next");
         wr(FIRST_ERR_OFS, 32'h1 << k);
         wr(NEXT_ERR_OFS, 32'h1 << k);
         fire(9'h001 << k);
         rd(NEXT_ERR_OFS, 32'h0, "next recapture");
         wr(FIRST_ERR_OFS, 32'h1 << k);
         rd(FIRST_ERR_OFS, 32'h0, "first cleared");
      end
   endtask
   task automatic t_serr;
      serr_en <= 1'b0;
      fire(9'h007);
      rd(FIRST_ERR_OFS, 32'h0, "masked msg");
      serr_en <= 1'b1;
   endtask
   task automatic t_same;
      fire(9'h1FF);
      rd(FIRST_ERR_OFS, 32'h1FF, "same cycle");
      wr(FIRST_ERR_OFS, 32'h0);
      wr(FIRST_ERR_OFS, 32'hFFFF_FE00);
      rd(FIRST_ERR_OFS, 32'h1FF, "zero write");
      fire(9'h1FF);
      rd(NEXT_ERR_OFS, 32'h1FF, "next all");
   endtask
   task automatic t_sticky;
      rst_pulse(1'b0);
      rd(FIRST_ERR_OFS, 32'h1FF, "first sticky");
      rd(NEXT_ERR_OFS, 32'h1FF, "next sticky");
      rst_pulse(1'b1);
      rd(NEXT_ERR_OFS, 32'h0, "power loss");
   endtask
   task automatic print_verdict;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   //=======================================================
   // Main sequence and watchdog
   initial begin
      repeat (10) @(posedge sys_clk);
      nrst <= 1'b1;
      por_n <= 1'b1;
      rd(FIRST_ERR_OFS, 32'h0, "first reset");
      rd(NEXT_ERR_OFS, 32'h0, "next reset");
      rd(12'h168, 32'h0, "unmapped");
      t_serr();
      t_bits();
      t_same();
      t_sticky();
      print_verdict();
   end
   initial begin
      repeat (4000) @(posedge sys_clk);
      err_total++;
      print_verdict();
   end
endmodule

// >>> src/err_log_field.sv
`timescale 1ns/100ps
//==================================================================
// One category's first/next capture pair
module err_log_field (
   input wire logic sys_clk, // Core clock
   input wire logic por_n, // Power-on reset, active low
   input wire logic err_evt, // Error event this cycle
   input wire logic clr_first, // Write-one clear of first bit
   input wire logic clr_next, // Write-one clear of next bit
   output logic first_reg, // First-error bit
   output logic next_reg // Next-error bit
);
   logic first_next; // Next value of first bit
   logic next_next; // Next value of next bit

   // Capture into first when free, else into next
   assign first_next = (first_reg & ~clr_first) | (err_evt & ~first_reg);
   assign next_next = (next_reg & ~clr_next) | (err_evt & first_reg);

   // Only power-on reset clears; system reset does not reach here
   always_ff @(posedge sys_clk or negedge por_n) begin
      if (!por_n) begin
         first_reg <= 1'b0;
         next_reg <= 1'b0;
      end else begin
         first_reg <= first_next;
         next_reg <= next_next;
      end
   end
endmodule

// >>> src/err_log_pkg.sv
//==================================================================
// Operation
// - First error per category locks its field
// - Same-cycle errors with first all latch
// - Logged bits survive system reset, cleared by software
// - Bits reset zero, write one clears
// - First-error bits 31:9 read zero
// - Bit 8: internal fatal error
// - Bit 7: device non-fatal error
// - Bit 6: device correctable error
// - Bit 5: unit-specific fatal error
// - Bit 4: unit-specific non-fatal error
// - Bit 3: unit-specific correctable error
// - Unit report mask never blocks logging
// - Bit 2: fatal message received
// - Bit 1: non-fatal message received
// - Bit 0: correctable message received
// - Messages masked when SERR enable zero
// - Next-error log at 164h, same layout
// - First-error log at 160h, write-one-clear
package err_log_pkg;
   //===============================================================
   // Register map
   localparam logic [11:0] FIRST_ERR_OFS = 12'h160; // First-error log
   localparam logic [11:0] NEXT_ERR_OFS = 12'h164; // Next-error log
   localparam int LOG_BITS = 9; // Defined error bits 8:0
   localparam logic [31:0] LOG_RESET = 32'h0000_0000; // Reset value
   // Field positions
   localparam int BIT_MSG_COR = 0;
   localparam int BIT_MSG_NONFATAL = 1;
   localparam int BIT_MSG_FATAL = 2;
   localparam int BIT_UNIT_COR = 3;
   localparam int BIT_UNIT_NONFATAL = 4;
   localparam int BIT_UNIT_FATAL = 5;
   localparam int BIT_DEV_COR = 6;
   localparam int BIT_DEV_NONFATAL = 7;
   localparam int BIT_DEV_FATAL = 8;
endpackage

// >>> src/pcie_port_error_first_next_log.sv
`timescale 1ns/100ps
//==================================================================
// Error first/next log for one root port
module pcie_port_error_first_next_log
   import err_log_pkg::*;
(
   input wire logic sys_clk, // Core clock, 40 MHz
   input wire logic nrst, // System reset, active low (logs survive it)
   input wire logic por_n, // Power-on reset, active low
   input wire logic dev_fatal_det, // Internal fatal error strobe
   input wire logic dev_nonfatal_det, // Device non-fatal error strobe
   input wire logic dev_cor_det, // Device correctable error strobe
   input wire logic unit_fatal_det, // Unit fatal error strobe
   input wire logic unit_nonfatal_det, // Unit non-fatal error strobe
   input wire logic unit_cor_det, // Unit correctable error strobe
   input wire logic msg_fatal_rx, // Fatal error message received
   input wire logic msg_nonfatal_rx, // Non-fatal error message received
   input wire logic msg_cor_rx, // Correctable error message received
   input wire logic serr_en, // SERR enable from bridge control
   input wire logic [11:0] reg_addr, // Register byte address
   input wire logic [31:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [31:0] reg_rdata // Read data, cycle after strobe
);
   //===============================================================
   // Event gathering
   logic [LOG_BITS-1:0] evt; // Error events by bit position
   logic [LOG_BITS-1:0] first_bits; // First-error log bits
   logic [LOG_BITS-1:0] next_bits; // Next-error log bits
   logic hit_first; // Address hits first-error log
   logic hit_next; // Address hits next-error log
   logic [LOG_BITS-1:0] clr_first; // Write-one clear mask, first
   logic [LOG_BITS-1:0] clr_next; // Write-one clear mask, next
   logic [31:0] rd_mux; // Selected read word
   logic [31:0] rdata_next; // Next read data

   assign evt[BIT_DEV_FATAL] = dev_fatal_det;
   assign evt[BIT_DEV_NONFATAL] = dev_nonfatal_det;
   assign evt[BIT_DEV_COR] = dev_cor_det;
   // Unit report mask is not applied here
   assign evt[BIT_UNIT_FATAL] = unit_fatal_det;
   assign evt[BIT_UNIT_NONFATAL] = unit_nonfatal_det;
   assign evt[BIT_UNIT_COR] = unit_cor_det;
   assign evt[BIT_MSG_FATAL] = msg_fatal_rx & serr_en;
   assign evt[BIT_MSG_NONFATAL] = msg_nonfatal_rx & serr_en;
   assign evt[BIT_MSG_COR] = msg_cor_rx & serr_en;

   //===============================================================
   // Register decode
   assign hit_first = (reg_addr == FIRST_ERR_OFS);
   assign hit_next = (reg_addr == NEXT_ERR_OFS);
   assign clr_first = (reg_wr & hit_first) ? reg_wdata[LOG_BITS-1:0] : '0;
   assign clr_next = (reg_wr & hit_next) ? reg_wdata[LOG_BITS-1:0] : '0;

   //===============================================================
   // Per-category capture; all same-cycle events land together
   for (genvar i = 0; i < LOG_BITS; i++) begin : g_field
      err_log_field u_field (
         .sys_clk(sys_clk),
         .por_n(por_n),
         .err_evt(evt[i]),
         .clr_first(clr_first[i]),
         .clr_next(clr_next[i]),
         .first_reg(first_bits[i]),
         .next_reg(next_bits[i])
      );
   end

   //===============================================================
   // Read path; reserved bits and unmapped addresses read zero
   assign rd_mux = hit_first ? {23'h000000, first_bits} :
                   hit_next ? {23'h000000, next_bits} : 32'h0000_0000;
   assign rdata_next = reg_rd ? rd_mux : 32'h0000_0000;

   // Read data register, cleared by system reset
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= LOG_RESET;
      end else begin
         reg_rdata <= rdata_next;
      end
   end

   //===============================================================
   // Checks
   AST_LOCK: assert property (@(posedge sys_clk) disable iff (!por_n)
      first_bits[0] && !clr_first[0] |=> first_bits[0])
      else $error("locked first bit dropped");
   AST_NEXT: assert property (@(posedge sys_clk) disable iff (!por_n)
      first_bits[BIT_DEV_FATAL] && dev_fatal_det |=> next_bits[BIT_DEV_FATAL])
      else $error("next log missed error");
   AST_SAME: assert property (@(posedge sys_clk) disable iff (!por_n)
      (first_bits == '0) && (evt != '0) |=> first_bits == $past(evt))
      else $error("same-cycle errors not latched");
   AST_SERR: assert property (@(posedge sys_clk) disable iff (!por_n)
      !serr_en && first_bits[2:0] == 3'h0 && !dev_cor_det |=> first_bits[2:0] == 3'h0)
      else $error("masked message logged");
   AST_CLR: assert property (@(posedge sys_clk) disable iff (!por_n)
      clr_next[3] && !unit_cor_det |=> !next_bits[3])
      else $error("write one did not clear");
   AST_RECAP: assert property (@(posedge sys_clk) disable iff (!por_n)
      clr_first[6] && first_bits[6] ##1 dev_cor_det |=> first_bits[6])
      else $error("cleared field not recaptured");
   AST_RSV: assert property (@(posedge sys_clk) disable iff (!nrst)
      reg_rd && hit_first |=> reg_rdata[31:9] == 23'h000000)
      else $error("reserved bits nonzero");
   AST_STICKY: assert property (@(posedge sys_clk) disable iff (!por_n)
      !nrst && first_bits[8] && !dev_fatal_det |=> first_bits[8])
      else $error("log lost on system reset");
   AST_READ: assert property (@(posedge sys_clk) disable iff (!nrst)
      reg_rd && hit_first |=> reg_rdata[8:0] == $past(first_bits))
      else $error("first log read wrong");
   //===============================================================
   // Per-category capture into a free first-error field
   // Device fatal strobe lands in bit 8
   AST_DEV_FATAL: assert property (@(posedge sys_clk) disable iff (!por_n)
      dev_fatal_det && !first_bits[BIT_DEV_FATAL] |=> first_bits[BIT_DEV_FATAL])
      else $error("device fatal not captured");
   // Device non-fatal strobe lands in bit 7
   AST_DEV_NONFATAL: assert property (@(posedge sys_clk) disable iff (!por_n)
      dev_nonfatal_det && !first_bits[BIT_DEV_NONFATAL] |=> first_bits[BIT_DEV_NONFATAL])
      else $error("device non-fatal not captured");
   // Device correctable strobe lands in bit 6
   AST_DEV_COR: assert property (@(posedge sys_clk) disable iff (!por_n)
      dev_cor_det && !first_bits[BIT_DEV_COR] |=> first_bits[BIT_DEV_COR])
      else $error("device correctable not captured");
   // Unit fatal strobe lands in bit 5 whatever the report mask says
   AST_UNIT_FATAL: assert property (@(posedge sys_clk) disable iff (!por_n)
      unit_fatal_det && !first_bits[BIT_UNIT_FATAL] |=> first_bits[BIT_UNIT_FATAL])
      else $error("unit fatal not captured");
   // Unit non-fatal strobe lands in bit 4
   AST_UNIT_NONFATAL: assert property (@(posedge sys_clk) disable iff (!por_n)
      unit_nonfatal_det && !first_bits[BIT_UNIT_NONFATAL] |=> first_bits[BIT_UNIT_NONFATAL])
      else $error("unit non-fatal not captured");
   // Unit correctable strobe lands in bit 3
   AST_UNIT_COR: assert property (@(posedge sys_clk) disable iff (!por_n)
      unit_cor_det && !first_bits[BIT_UNIT_COR] |=> first_bits[BIT_UNIT_COR])
      else $error("unit correctable not captured");
   // Fatal message with SERR enable set lands in bit 2
   AST_MSG_FATAL: assert property (@(posedge sys_clk) disable iff (!por_n)
      msg_fatal_rx && serr_en && !first_bits[BIT_MSG_FATAL] |=> first_bits[BIT_MSG_FATAL])
      else $error("fatal message not captured");
   // Non-fatal message with SERR enable set lands in bit 1
   AST_MSG_NONFATAL: assert property (@(posedge sys_clk) disable iff (!por_n)
      msg_nonfatal_rx && serr_en && !first_bits[BIT_MSG_NONFATAL]
      |=> first_bits[BIT_MSG_NONFATAL])
      else $error("non-fatal message not captured");
   // Correctable message with SERR enable set lands in bit 0
   AST_MSG_COR: assert property (@(posedge sys_clk) disable iff (!por_n)
      msg_cor_rx && serr_en && !first_bits[BIT_MSG_COR] |=> first_bits[BIT_MSG_COR])
      else $error("correctable message not captured");

   //===============================================================
   // Next-error log behaviour
   // An event on a free first field never reaches the next log
   AST_NEXT_FREE: assert property (@(posedge sys_clk) disable iff (!por_n)
      !first_bits[BIT_DEV_COR] && !next_bits[BIT_DEV_COR] |=> !next_bits[BIT_DEV_COR])
      else $error("next log set while first free");
   // A next bit holds until written with one
   AST_NEXT_HOLD: assert property (@(posedge sys_clk) disable iff (!por_n)
      next_bits[BIT_UNIT_FATAL] && !clr_next[BIT_UNIT_FATAL] |=> next_bits[BIT_UNIT_FATAL])
      else $error("next bit dropped");
   // Writing zero leaves a logged bit alone
   AST_ZERO_WR: assert property (@(posedge sys_clk) disable iff (!por_n)
      reg_wr && hit_first && !reg_wdata[BIT_DEV_NONFATAL] && first_bits[BIT_DEV_NONFATAL]
      |=> first_bits[BIT_DEV_NONFATAL])
      else $error("zero write changed bit");

   //===============================================================
   // Read path behaviour
   // Next log reads back in the cycle after the strobe
   AST_RD_NEXT: assert property (@(posedge sys_clk) disable iff (!nrst)
      reg_rd && hit_next |=> reg_rdata[8:0] == $past(next_bits))
      else $error("next log read wrong");
   // Unmapped addresses read zero
   AST_RD_NONE: assert property (@(posedge sys_clk) disable iff (!nrst)
      reg_rd && !hit_first && !hit_next |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped read nonzero");
   // Read data stand only in the cycle after a read
   AST_RD_IDLE: assert property (@(posedge sys_clk) disable iff (!nrst)
      !reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside read cycle");

   //===============================================================
   // Scenario covers
   COV_RECAP: cover property (@(posedge sys_clk) disable iff (!por_n)
      clr_first[BIT_DEV_COR] ##1 dev_cor_det ##1 first_bits[BIT_DEV_COR]);
   COV_SAME: cover property (@(posedge sys_clk) disable iff (!por_n)
      first_bits == '0 ##1 first_bits == 9'h1FF);
   COV_FIRST: cover property (@(posedge sys_clk) disable iff (!por_n)
      dev_fatal_det ##1 first_bits[8]);
   COV_NEXT: cover property (@(posedge sys_clk) disable iff (!por_n)
      first_bits[0] && msg_cor_rx && serr_en);
   COV_CLR: cover property (@(posedge sys_clk) disable iff (!por_n)
      clr_first != '0 && first_bits != '0);
endmodule
